// *** scrp_pkg.sv ***
// Purpose: constants for the switch control register port
// Assumes: 16-bit host data, 8-bit host address
// Notes:   register map, field positions, rate codes
package scrp_pkg;
    localparam int DW = 16;
    localparam int AW = 8;
    // register select and offsets
    localparam int          ADDR_MEM_BIT   = 7;
    localparam logic [6:0]  OFS_CTRL       = 7'h00;
    localparam logic [6:0]  OFS_IMS        = 7'h01;
    localparam logic [15:0] RST_VAL        = 16'h0000;
    // switch_control fields
    localparam int CTL_ARM_BIT  = 5;
    localparam int CTL_MSEL_BIT = 4;
    localparam int CTL_STR_HI   = 3;
    localparam int CTL_USED_W   = 6;
    // interface_mode_select fields
    localparam int IMS_BFD_LO   = 5;
    localparam int IMS_BFD_HI   = 9;
    localparam int IMS_GO_BIT   = 4;
    localparam int IMS_STBY_BIT = 3;
    localparam int IMS_FES_BIT  = 2;
    localparam int IMS_RATE_HI  = 1;
    localparam int IMS_USED_W   = 10;
    // connection memory word layout
    localparam int CM_FILL_LO   = 11;
    // rate codes
    localparam logic [1:0] RATE_2M   = 2'h0;
    localparam logic [1:0] RATE_4M   = 2'h1;
    localparam logic [1:0] RATE_8M   = 2'h2;
    localparam logic [1:0] RATE_RSVD = 2'h3;
    localparam logic [6:0] CH_MASK_2M = 7'h1F;
    localparam logic [6:0] CH_MASK_4M = 7'h3F;
    localparam logic [6:0] CH_MASK_8M = 7'h7F;
    typedef enum logic [1:0] {
        SCRP_IDLE = 2'h0,
        SCRP_FILL = 2'h1,
        SCRP_DONE = 2'h3
    } scrp_fill_t;
endpackage

// *** scrp_mem_if.sv ***
// Purpose: memory-side bundle between register port and address decoder
// Assumes: single clock
// Notes:   none
`timescale 1ns/100ps
interface scrp_mem_if;
    logic [1:0] rate;
    logic [6:0] addr;
    logic [6:0] chan;
    modport ctrl (output rate, output addr, input chan);
    modport dec  (input rate, input addr, output chan);
endinterface

// *** scrp_chan_dec.sv ***
// Purpose: rate-dependent channel index masking
// Assumes: rate code held stable between accesses
// Notes:   reserved rate code treated as widest mask
`timescale 1ns/100ps
module scrp_chan_dec (
    scrp_mem_if.dec m
);
    logic [6:0] mask;
    always_comb begin
        unique case (m.rate)
            scrp_pkg::RATE_2M: mask = scrp_pkg::CH_MASK_2M;
            scrp_pkg::RATE_4M: mask = scrp_pkg::CH_MASK_4M;
            default:           mask = scrp_pkg::CH_MASK_8M;
        endcase
    end
    assign m.chan = m.addr & mask;
endmodule // scrp_chan_dec

// *** scrp_top.sv ***
// Purpose: host register port of a time-slot switch
// Assumes: synchronous host strobes, one access per cycle
// Notes:   switching datapath lies outside; memory reached by ports
// How it works
// - drive pin or standby bit hands over control
// - control resets zero, bits 15..6 unused
// - bit 5 arms block programming
// - select zero: memory access hits connection
// - select one: read data, write connection
// - bits 3..0 pick stream subsection
// - channel index uses rate-valid lines only
// - mode register at 01, resets zero
// - address bit 7 picks memory vs register
// - drive pin overrides standby bit
// - block fill loads 15..11, clears 10..0
// - rate codes 00/01/10, 11 reserved
`timescale 1ns/100ps
module scrp_top #(
    parameter int FILL_CYCLES = 8
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // host port
    input  wire logic        i_cs,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    // pins
    input  wire logic        i_output_drive_enable_pin,
    output logic             o_outputs_enabled,
    output logic             o_rate_reserved,
    // connection memory port
    output logic             o_cm_we,
    output logic [3:0]       o_cm_stream,
    output logic [6:0]       o_cm_chan,
    output logic [15:0]      o_cm_wdata,
    output logic             o_cm_fill,
    output logic [4:0]       o_cm_fill_data,
    input  wire logic [15:0] i_cm_rdata,
    input  wire logic [15:0] i_dm_rdata
);
    // fill counter is 16 bits wide
    if (FILL_CYCLES < 1 || FILL_CYCLES > 65535) begin : g_bad_fill
        $error("FILL_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [5:0]  ctl_q, ctl_d;
    logic [9:0]  ims_q, ims_d;
    logic [15:0] rd_q, rd_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] fill_len_q, fill_len_d;
    scrp_pkg::scrp_fill_t st_q, st_d;
    logic is_mem, wr_ctl, wr_ims, go_rise, abort;
    scrp_mem_if mif ();

    assign is_mem = i_addr[scrp_pkg::ADDR_MEM_BIT];
    assign wr_ctl = i_cs & i_wr & ~is_mem & (i_addr[6:0] == scrp_pkg::OFS_CTRL);
    assign wr_ims = i_cs & i_wr & ~is_mem & (i_addr[6:0] == scrp_pkg::OFS_IMS);
    assign go_rise = wr_ims & i_wdata[scrp_pkg::IMS_GO_BIT]
                   & ~ims_q[scrp_pkg::IMS_GO_BIT];
    assign abort = (st_q == scrp_pkg::SCRP_FILL)
                 & ((wr_ims & ~i_wdata[scrp_pkg::IMS_GO_BIT])
                 | (wr_ctl & ~i_wdata[scrp_pkg::CTL_ARM_BIT]));

    assign mif.rate = ims_q[scrp_pkg::IMS_RATE_HI:0];
    assign mif.addr = i_addr[6:0];
    scrp_chan_dec u_dec (.m(mif.dec));

    ////////////////////////////////////////////////////////////////////////
    // registers and fill sequencer
    always_comb begin
        ctl_d = ctl_q;
        ims_d = ims_q;
        st_d  = st_q;
        cnt_d = cnt_q;
        if (wr_ctl)
            ctl_d = i_wdata[scrp_pkg::CTL_USED_W-1:0];
        if (wr_ims)
            ims_d = i_wdata[scrp_pkg::IMS_USED_W-1:0];
        unique case (st_q)
            scrp_pkg::SCRP_IDLE: begin
                if (go_rise && ctl_d[scrp_pkg::CTL_ARM_BIT]) begin
                    st_d  = scrp_pkg::SCRP_FILL;
                    cnt_d = 16'(FILL_CYCLES - 1);
                end
            end
            scrp_pkg::SCRP_FILL: begin
                if (abort)
                    st_d = scrp_pkg::SCRP_IDLE;
                else if (cnt_q == 16'h0000)
                    st_d = scrp_pkg::SCRP_DONE;
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            default: begin
                // go bit returns to zero when done
                ims_d[scrp_pkg::IMS_GO_BIT] = 1'b0;
                st_d = scrp_pkg::SCRP_IDLE;
            end
        endcase
        if (!i_rst_n) begin
            ctl_d = '0;
            ims_d = '0;
            st_d  = scrp_pkg::SCRP_IDLE;
            cnt_d = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, one cycle latency
    always_comb begin
        rd_d = rd_q;
        if (i_cs && !i_wr) begin
            if (is_mem) begin
                rd_d = ctl_q[scrp_pkg::CTL_MSEL_BIT] ? i_dm_rdata : i_cm_rdata;
            end else if (i_addr[6:0] == scrp_pkg::OFS_CTRL) begin
                rd_d = {10'h000, ctl_q};
            end else if (i_addr[6:0] == scrp_pkg::OFS_IMS) begin
                rd_d = {6'h00, ims_q};
            end else begin
                rd_d = 16'h0000;
            end
        end
        if (!i_rst_n)
            rd_d = scrp_pkg::RST_VAL;
    end

    always_ff @(posedge i_clk) begin
        ctl_q <= ctl_d;
        ims_q <= ims_d;
        st_q  <= st_d;
        cnt_q <= cnt_d;
        rd_q  <= rd_d;
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_rdata = rd_q;
    assign o_cm_we = i_cs & i_wr & is_mem & (st_q != scrp_pkg::SCRP_FILL);
    assign o_cm_stream = ctl_q[scrp_pkg::CTL_STR_HI:0];
    assign o_cm_chan   = mif.chan;
    assign o_cm_wdata  = i_wdata;
    // fill word 15..11, rest cleared by memory
    assign o_cm_fill = (st_q == scrp_pkg::SCRP_FILL);
    assign o_cm_fill_data = ims_q[scrp_pkg::IMS_BFD_HI:scrp_pkg::IMS_BFD_LO];
    assign o_outputs_enabled = i_output_drive_enable_pin
                             | ims_q[scrp_pkg::IMS_STBY_BIT];
    assign o_rate_reserved = (ims_q[scrp_pkg::IMS_RATE_HI:0]
                              == scrp_pkg::RATE_RSVD);

    ////////////////////////////////////////////////////////////////////////
    // fill cycles seen so far, only for the checks below
    always_comb begin
        fill_len_d = 16'h0000;
        if (i_rst_n && o_cm_fill)
            fill_len_d = fill_len_q + 16'h0001;
    end

    always_ff @(posedge i_clk) begin
        fill_len_q <= fill_len_d;
    end

    ////////////////////////////////////////////////////////////////////////
    a_ctrl_reset_zero: assert property (@(posedge i_clk)
        !i_rst_n |=> ctl_q == 6'h00 && ims_q == 10'h000)
        else $error("registers not zero after reset");
    a_fill_needs_arm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_cm_fill) |-> $past(ctl_d[scrp_pkg::CTL_ARM_BIT]))
        else $error("fill started without arm");
    a_read_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cs && !i_wr && is_mem && ctl_q[scrp_pkg::CTL_MSEL_BIT]
        |=> o_rdata == $past(i_dm_rdata))
        else $error("data memory read wrong");
    a_read_conn: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cs && !i_wr && is_mem && !ctl_q[scrp_pkg::CTL_MSEL_BIT]
        |=> o_rdata == $past(i_cm_rdata))
        else $error("connection memory read wrong");
    a_stream_field: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_ctl |=> o_cm_stream == $past(i_wdata[3:0]))
        else $error("stream field wrong");
    a_chan_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ims_q[1:0] == scrp_pkg::RATE_2M |-> o_cm_chan[6:5] == 2'h0)
        else $error("channel beyond 2M range");
    a_ims_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_ims && !i_wdata[scrp_pkg::IMS_GO_BIT]
        |=> ims_q == $past(i_wdata[9:0]))
        else $error("mode register write lost");
    a_mem_no_reg: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cs && i_wr && is_mem |=> $stable(ctl_q) || $past(wr_ctl))
        else $error("memory write hit register");
    a_drive_override: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_output_drive_enable_pin |-> o_outputs_enabled)
        else $error("drive pin not honoured");
    a_fill_bound: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        o_cm_fill |-> fill_len_q < 16'(FILL_CYCLES))
        else $error("fill ran too long");
    a_fill_length: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        $fell(o_cm_fill)
        |-> $past(abort) || $past(fill_len_q) == 16'(FILL_CYCLES - 1))
        else $error("fill length wrong");
    c_fill: cover property (@(posedge i_clk) $fell(o_cm_fill));
    c_dm_read: cover property (@(posedge i_clk)
        i_cs && !i_wr && is_mem && ctl_q[scrp_pkg::CTL_MSEL_BIT]);
    c_rate8: cover property (@(posedge i_clk) ims_q[1:0] == scrp_pkg::RATE_8M);
endmodule // scrp_top

// *** scrp_mem_model.sv ***
// Purpose: connection and data memory behind the register port
// Assumes: one clock, writes taken on the rising edge
// Notes:   data memory is a fixed pattern, never written
`timescale 1ns/100ps
module scrp_mem_model (
    // clock
    input  wire logic        i_clk,
    // memory port from the block
    input  wire logic        i_cm_we,
    input  wire logic [3:0]  i_cm_stream,
    input  wire logic [6:0]  i_cm_chan,
    input  wire logic [15:0] i_cm_wdata,
    input  wire logic        i_cm_fill,
    input  wire logic [4:0]  i_cm_fill_data,
    // read data back to the block
    output logic      [15:0] o_cm_rdata,
    output logic      [15:0] o_dm_rdata
);
    logic [15:0] cm [2048];
    initial for (int i = 0; i < 2048; i++) cm[i] = 16'h0000;
    always @(posedge i_clk) begin
        if (i_cm_fill)
            for (int i = 0; i < 2048; i++) cm[i] = {i_cm_fill_data, 11'h000};
        else if (i_cm_we)
            cm[{i_cm_stream, i_cm_chan}] = i_cm_wdata;
    end
    assign o_cm_rdata = cm[{i_cm_stream, i_cm_chan}];
    assign o_dm_rdata = {5'h00, i_cm_stream, i_cm_chan} ^ 16'h5A5A;
endmodule // scrp_mem_model

// *** tb.sv ***
// Purpose: self-checking bench for the switch control register port
// Assumes: fill shortened to 4 cycles
// Notes:   host strobes driven on the falling edge
`timescale 1ns/100ps
module tb;
    localparam int FILLN = 4;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_cs = 1'b0;
    logic        i_wr = 1'b0;
    // drive pin low until set up
    logic        i_pin = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] o_rdata, cm_wdata, cm_rd, dm_rd;
    logic [6:0]  cm_chan;
    logic [4:0]  fill_data;
    logic [3:0]  cm_stream;
    logic        o_en, o_rsv, cm_we, cm_fill;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          n;
    scrp_top #(.FILL_CYCLES(FILLN)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_cs(i_cs), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .i_output_drive_enable_pin(i_pin),
        .o_outputs_enabled(o_en), .o_rate_reserved(o_rsv),
        .o_cm_we(cm_we), .o_cm_stream(cm_stream), .o_cm_chan(cm_chan),
        .o_cm_wdata(cm_wdata), .o_cm_fill(cm_fill),
        .o_cm_fill_data(fill_data), .i_cm_rdata(cm_rd), .i_dm_rdata(dm_rd));
    scrp_mem_model mem (.i_clk(i_clk), .i_cm_we(cm_we),
        .i_cm_stream(cm_stream), .i_cm_chan(cm_chan), .i_cm_wdata(cm_wdata),
        .i_cm_fill(cm_fill), .i_cm_fill_data(fill_data),
        .o_cm_rdata(cm_rd), .o_dm_rdata(dm_rd));
    initial forever #25 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        @(negedge i_clk);
        i_cs = 1'b1;
        i_wr = w;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_cs = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        check(o_rdata, exp);
    endtask
    task automatic count_fill;
        n = 0;
        // first fill cycle is already showing when called
        repeat (20) begin
            if (cm_fill === 1'b1) n++;
            @(negedge i_clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'h0000);
        acc(1'b1, 8'h00, 16'hFFFF);
        rd(8'h00, 16'h003F);
        acc(1'b1, 8'h01, 16'hFFEF);
        rd(8'h01, 16'h03EF);
        check({15'h0000, o_rsv}, 16'h0001);
        acc(1'b1, 8'h01, 16'h0000);
        check({15'h0000, o_rsv}, 16'h0000);
        rd(8'h02, 16'h0000);
    endtask
    task automatic t_drive;
        check({15'h0000, o_en}, 16'h0000);
        acc(1'b1, 8'h01, 16'h0008);
        check({15'h0000, o_en}, 16'h0001);
        acc(1'b1, 8'h01, 16'h0000);
        i_pin = 1'b1;
        @(negedge i_clk);
        check({15'h0000, o_en}, 16'h0001);
        i_pin = 1'b0;
    endtask
    task automatic t_mem;
        acc(1'b1, 8'h00, 16'h0003);
        acc(1'b1, 8'hA5, 16'h1234);
        rd(8'h85, 16'h1234);
        acc(1'b1, 8'h01, 16'h0002);
        rd(8'hA5, 16'h0000);
        acc(1'b1, 8'h01, 16'h0001);
        rd(8'hC5, 16'h1234);
        acc(1'b1, 8'h01, 16'h0000);
        acc(1'b1, 8'h00, 16'h0004);
        rd(8'h85, 16'h0000);
        acc(1'b1, 8'h00, 16'h0013);
        rd(8'h85, 16'h0185 ^ 16'h5A5A);
        acc(1'b1, 8'h86, 16'h7777);
        acc(1'b1, 8'h00, 16'h0003);
        rd(8'h86, 16'h7777);
    endtask
    task automatic t_fill;
        acc(1'b1, 8'h01, 16'h02B0);
        count_fill();
        check(16'(n), 16'h0000);
        acc(1'b1, 8'h01, 16'h0000);
        acc(1'b1, 8'h00, 16'h0023);
        acc(1'b1, 8'h01, 16'h02B0);
        count_fill();
        check(16'(n), 16'(FILLN));
        rd(8'h01, 16'h02A0);
        rd(8'h85, 16'hA800);
    endtask
    task automatic t_abort;
        acc(1'b1, 8'h01, 16'h02B0);
        check({15'h0000, cm_fill}, 16'h0001);
        // clearing the arm bit cuts the fill short
        acc(1'b1, 8'h00, 16'h0003);
        check({15'h0000, cm_fill}, 16'h0000);
        rd(8'h01, 16'h02B0);
    endtask
    task automatic t_reset;
        @(negedge i_clk);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        check(o_rdata, 16'h0000);
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_regs();
        t_drive();
        t_mem();
        t_fill();
        t_abort();
        t_reset();
        report_and_stop();
    end
endmodule // tb
